/* File: include/pswdc_map.svh */
// Register offsets, field positions, reset values and timing counts for the power-save block
//
// Contract
// RL1: Interrupt during power-save instruction is held until Sleep/Idle entry completes, then wakes.
// RL2: Power-on reset from supply monitor resets the whole block.
// RL3: Wake pin below input-low threshold in Sleep wakes the device.
// RL4: Wake by the low-power unit sets wake interrupt flag, bit 0 of flag reg 5.
// RL5: Wake control bit 15 enables the wake unit.
// RL6: Wake control bit 13 halts the wake unit in Idle.
// RL7: Wake control bit 8 turns the pin current sink on; the code also requires enable bit 15 for the sink to turn on.
// RL8: Wake control bits 14, 12:9, 7:0 read as zero.
// RL9: Software charges pin, makes it input, enables unit and sink, then sleeps.
// RL10: Sleep-regulator bit clear puts main regulator in standby in Sleep; set keeps full power.
// RL11: Retention regulator enabled only with fuse 0 and retention enable 1.
// RL12: Fuse 0, retention 1, sleep-regulator 0: main regulator off in Sleep.
// RL13: Fuse 1 keeps retention regulator off; sleep-regulator bit alone selects mode.
// RL14: Retention regulator used only in Sleep, never in Run.
// RL15: Wake from retention Sleep re-enables main regulator and waits for supply.
// RL16: Doze enable, clock divider bit 11, slows only the CPU clock.
// RL17: Doze ratio bits 14:12 select 1:1 to 1:128, default 1:1.
// RL18: Doze keeps CPU enable aligned to the peripheral clock.
// RL19: Return-on-interrupt bit 15 makes interrupts restore full CPU speed.
// RL20: Ratio code n divides by two to the power n.
// RL21: Interrupt ending doze clears the doze enable bit.
`ifndef PSWDC_MAP_SVH
`define PSWDC_MAP_SVH

// Byte offsets on the register bus
`define PSWDC_OFS_WAKE_CTRL   8'h00
`define PSWDC_OFS_RESET_CTRL  8'h04
`define PSWDC_OFS_CLK_DIV     8'h08
`define PSWDC_OFS_IFLAG5      8'h0c
`define PSWDC_OFS_STATUS      8'h10

// Field positions
`define PSWDC_WAKE_EN_BIT     15
`define PSWDC_WAKE_SIDL_BIT   13
`define PSWDC_WAKE_SINK_BIT   8
`define PSWDC_RC_RETENTION_ENABLE_BIT    12
`define PSWDC_RC_SLPREG_BIT   8
`define PSWDC_CD_ROI_BIT      15
`define PSWDC_CD_RATIO_HI     14
`define PSWDC_CD_RATIO_LO     12
`define PSWDC_CD_DOZE_ENABLE_BIT    11
`define PSWDC_IF5_WAKE_BIT    0

// Reset values
`define PSWDC_RST_WAKE_CTRL   16'h0000
`define PSWDC_RST_RESET_CTRL  16'h0000
`define PSWDC_RST_CLK_DIV     16'h0000

// Supply settle time after main regulator re-enable
`define PSWDC_SETTLE_NS       2000
`define PSWDC_CLK_NS          10
`define PSWDC_SETTLE_CYC      ((`PSWDC_SETTLE_NS + `PSWDC_CLK_NS - 1) / `PSWDC_CLK_NS)

`endif

/* File: include/pswdc_pkg.sv */
// Types shared by the power-save block
package pswdc_pkg;

    typedef enum logic [1:0] {
        PSWDC_MODE_RUN,
        PSWDC_MODE_IDLE,
        PSWDC_MODE_SLEEP
    } pswdc_mode_t;

    typedef enum logic [1:0] {
        PSWDC_REG_FULL,
        PSWDC_REG_STANDBY,
        PSWDC_REG_OFF
    } pswdc_reg_state_t;

    // Regulator control outputs
    typedef struct packed {
        pswdc_reg_state_t main_state;
        logic             retention_on;
        logic             flash_powered;
    } pswdc_regulator_t;

    // Power-save instruction request from the core
    typedef struct packed {
        logic valid;
        logic to_sleep;
    } pswdc_psave_req_t;

endpackage

/* File: core/pswdc_ctrl.sv */
// Power-save sequencing, low-power wake, regulator selection and doze divider
`timescale 1ns/100ps
`default_nettype none
`include "pswdc_map.svh"

module pswdc_ctrl
    import pswdc_pkg::*;
(
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // Supply monitor power-on reset
    input  wire logic              por_n,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [7:0]        haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Core side
    input  wire pswdc_psave_req_t  psave_req,
    input  wire logic              irq_pending,
    output logic                   cpu_clk_en,
    output logic                   core_asleep,
    output logic                   wake_event,
    // Fuse and wake pin
    input  wire logic              retention_config_fuse,
    input  wire logic              wake_sense_pin,
    output logic                   wake_sink_on,
    output pswdc_regulator_t       regulator
);

    // ----------------------------------------------------------------
    // Reset and pin synchronisers
    // ----------------------------------------------------------------
    logic       rst_n;
    logic [1:0] pin_sync;
    logic [1:0] fuse_sync;

    // Supply-monitor reset joins bus reset; all state below clears on it
    assign rst_n = hresetn & por_n; // RL2

    // Two-flop synchronisers for the pin and the fuse level
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync  <= 2'h3;
            fuse_sync <= 2'h3;
        end else begin
            pin_sync  <= {pin_sync[0], wake_sense_pin};
            fuse_sync <= {fuse_sync[0], retention_config_fuse};
        end
    end

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic [15:0] wake_ctrl;
    logic [15:0] reset_ctrl;
    logic [15:0] clk_div;
    logic        wake_flag;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        rd_go;
    logic        set_flag;
    logic        clr_doze;
    pswdc_mode_t mode;
    pswdc_reg_state_t main_state;

    // Zero-wait slave: every transfer completes in one data phase
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign rd_go     = hsel & hready & htrans[1] & ~hwrite;

    // Capture address phase of writes
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= hsel & htrans[1] & hwrite;
            wr_addr <= haddr;
        end
    end

    // Wake control: only bits 15, 13, 8 are stored
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            wake_ctrl <= `PSWDC_RST_WAKE_CTRL;
        end else if (wr_pend && wr_addr == `PSWDC_OFS_WAKE_CTRL) begin
            wake_ctrl <= hwdata[15:0] & 16'ha100; // RL8
        end
    end

    // Reset control: retention enable and sleep-regulator bits
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            reset_ctrl <= `PSWDC_RST_RESET_CTRL;
        end else if (wr_pend && wr_addr == `PSWDC_OFS_RESET_CTRL) begin
            reset_ctrl <= hwdata[15:0] & 16'h1100;
        end
    end

    // Clock divider; hardware clear of doze enable wins over a write
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            clk_div <= `PSWDC_RST_CLK_DIV; // RL17
        end else begin
            if (wr_pend && wr_addr == `PSWDC_OFS_CLK_DIV) begin
                clk_div <= hwdata[15:0] & 16'hf800;
            end
            if (clr_doze) begin
                clk_div[`PSWDC_CD_DOZE_ENABLE_BIT] <= 1'b0; // RL21
            end
        end
    end

    // Wake flag: hardware set wins over software clear
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            wake_flag <= 1'b0;
        end else if (set_flag) begin
            wake_flag <= 1'b1; // RL4
        end else if (wr_pend && wr_addr == `PSWDC_OFS_IFLAG5) begin
            wake_flag <= hwdata[`PSWDC_IF5_WAKE_BIT];
        end
    end

    // Read data registered; unmapped offsets read zero
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_go) begin
            unique case (haddr)
                `PSWDC_OFS_WAKE_CTRL:  hrdata <= {16'h0000, wake_ctrl}; // RL8
                `PSWDC_OFS_RESET_CTRL: hrdata <= {16'h0000, reset_ctrl};
                `PSWDC_OFS_CLK_DIV:    hrdata <= {16'h0000, clk_div};
                `PSWDC_OFS_IFLAG5:     hrdata <= {31'h0, wake_flag};
                `PSWDC_OFS_STATUS:     hrdata <= {26'h0, fuse_sync[1], pin_sync[1],
                                                  main_state, mode};
                default:               hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Power-save sequencing
    // ----------------------------------------------------------------
    logic wake_unit_live;
    logic pin_low;
    logic ulp_wake;
    logic irq_held;
    logic retention_sel;
    logic [7:0] settle_cnt;
    logic settling;

    assign pin_low = ~pin_sync[1]; // RL3
    // Unit runs when enabled, except in Idle with stop-in-idle set
    assign wake_unit_live = wake_ctrl[`PSWDC_WAKE_EN_BIT] // RL5
                          & ~(mode == PSWDC_MODE_IDLE
                              & wake_ctrl[`PSWDC_WAKE_SIDL_BIT]); // RL6
    assign ulp_wake = wake_unit_live & pin_low & (mode == PSWDC_MODE_SLEEP); // RL3
    assign set_flag = ulp_wake;
    assign wake_sink_on = wake_ctrl[`PSWDC_WAKE_EN_BIT] & wake_ctrl[`PSWDC_WAKE_SINK_BIT]; // RL7
    assign retention_sel = ~fuse_sync[1] & reset_ctrl[`PSWDC_RC_RETENTION_ENABLE_BIT] // RL11 RL13
                         & ~reset_ctrl[`PSWDC_RC_SLPREG_BIT]; // RL12

    // Interrupt seen during entry is parked until the mode is entered
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_held <= 1'b0;
        end else if (psave_req.valid && irq_pending && mode == PSWDC_MODE_RUN) begin
            irq_held <= 1'b1; // RL1
        end else if (mode != PSWDC_MODE_RUN) begin
            irq_held <= 1'b0;
        end
    end

    // Mode tracking; wake from retention waits for the supply to settle
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            mode       <= PSWDC_MODE_RUN;
            settle_cnt <= 8'h00;
            settling   <= 1'b0;
            wake_event <= 1'b0;
        end else begin
            wake_event <= 1'b0;
            if (settling) begin
                if (settle_cnt == 8'h00) begin
                    settling   <= 1'b0;
                    mode       <= PSWDC_MODE_RUN;
                    wake_event <= 1'b1;
                end else begin
                    settle_cnt <= settle_cnt - 8'h01; // RL15
                end
            end else begin
                unique case (mode)
                    PSWDC_MODE_RUN: begin
                        if (psave_req.valid) begin
                            mode <= psave_req.to_sleep ? PSWDC_MODE_SLEEP : PSWDC_MODE_IDLE;
                        end
                    end
                    PSWDC_MODE_IDLE: begin
                        if (irq_pending || irq_held) begin
                            mode       <= PSWDC_MODE_RUN; // RL1
                            wake_event <= 1'b1;
                        end
                    end
                    PSWDC_MODE_SLEEP: begin
                        if (irq_pending || irq_held || ulp_wake) begin
                            if (retention_sel) begin
                                settling   <= 1'b1; // RL15
                                settle_cnt <= 8'(`PSWDC_SETTLE_CYC - 1);
                            end else begin
                                mode       <= PSWDC_MODE_RUN; // RL3
                                wake_event <= 1'b1;
                            end
                        end
                    end
                    default: mode <= PSWDC_MODE_RUN;
                endcase
            end
        end
    end

    // Regulator state during sleep
    always_comb begin
        main_state = PSWDC_REG_FULL;
        if (mode == PSWDC_MODE_SLEEP && !settling) begin
            if (retention_sel) begin
                main_state = PSWDC_REG_OFF; // RL12
            end else if (!reset_ctrl[`PSWDC_RC_SLPREG_BIT]) begin
                main_state = PSWDC_REG_STANDBY; // RL10
            end
        end
    end

    assign regulator.main_state    = main_state;
    assign regulator.retention_on  = retention_sel & (mode == PSWDC_MODE_SLEEP); // RL14
    assign regulator.flash_powered = (mode != PSWDC_MODE_SLEEP)
                                   | reset_ctrl[`PSWDC_RC_SLPREG_BIT]; // RL10
    assign core_asleep = (mode != PSWDC_MODE_RUN);

    // ----------------------------------------------------------------
    // Doze divider
    // ----------------------------------------------------------------
    logic [6:0] doze_cnt;
    logic [6:0] doze_top;

    // Code n divides by 2**n
    assign doze_top = 7'((8'h01 << clk_div[`PSWDC_CD_RATIO_HI:`PSWDC_CD_RATIO_LO]) - 8'h01); // RL20
    // Return-on-interrupt drops doze at once on any pending interrupt
    assign clr_doze = clk_div[`PSWDC_CD_ROI_BIT] & clk_div[`PSWDC_CD_DOZE_ENABLE_BIT]
                    & irq_pending; // RL19

    // Counter runs on the peripheral clock so CPU enables stay aligned to it
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            doze_cnt <= 7'h00;
        end else if (!clk_div[`PSWDC_CD_DOZE_ENABLE_BIT] || doze_cnt >= doze_top) begin
            doze_cnt <= 7'h00; // RL18
        end else begin
            doze_cnt <= doze_cnt + 7'h01;
        end
    end

    // Only the CPU enable is thinned; peripherals keep hclk
    assign cpu_clk_en = (mode == PSWDC_MODE_RUN) & ~settling
                      & (~clk_div[`PSWDC_CD_DOZE_ENABLE_BIT] | clr_doze
                         | doze_cnt == 7'h00); // RL16 RL17

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_flag_on_wake;
        @(posedge hclk) disable iff (!rst_n) ulp_wake |=> wake_flag;
    endproperty
    a_flag_on_wake: assert property (p_flag_on_wake) else $error("wake flag not set"); // RL4

    property p_unused_zero;
        @(posedge hclk) disable iff (!rst_n)
            (rd_go && haddr == `PSWDC_OFS_WAKE_CTRL) |=> (hrdata[15:0] & 16'h5eff) == 16'h0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits nonzero"); // RL8

    property p_sink;
        @(posedge hclk) disable iff (!rst_n)
            wake_sink_on |-> wake_ctrl[`PSWDC_WAKE_SINK_BIT] && wake_ctrl[`PSWDC_WAKE_EN_BIT];
    endproperty
    a_sink: assert property (p_sink) else $error("sink on without enable"); // RL7

    property p_idle_stop;
        @(posedge hclk) disable iff (!rst_n)
            (mode == PSWDC_MODE_IDLE && wake_ctrl[`PSWDC_WAKE_SIDL_BIT]) |-> !wake_unit_live;
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("unit live in idle"); // RL6

    property p_ret_fuse;
        @(posedge hclk) disable iff (!rst_n) fuse_sync[1] |-> !regulator.retention_on;
    endproperty
    a_ret_fuse: assert property (p_ret_fuse) else $error("retention with fuse set"); // RL13

    property p_ret_run;
        @(posedge hclk) disable iff (!rst_n)
            (mode == PSWDC_MODE_RUN) |-> !regulator.retention_on && main_state == PSWDC_REG_FULL;
    endproperty
    a_ret_run: assert property (p_ret_run) else $error("retention used in run"); // RL14

    property p_settle;
        @(posedge hclk) disable iff (!rst_n)
            $rose(settling) |-> !cpu_clk_en [*8];
    endproperty
    a_settle: assert property (p_settle) else $error("cpu ran before settle"); // RL15

    property p_held_wake;
        @(posedge hclk) disable iff (!rst_n)
            (irq_held && mode == PSWDC_MODE_IDLE) |=> mode == PSWDC_MODE_RUN;
    endproperty
    a_held_wake: assert property (p_held_wake) else $error("held irq did not wake"); // RL1

    property p_roi;
        @(posedge hclk) disable iff (!rst_n) clr_doze |=> !clk_div[`PSWDC_CD_DOZE_ENABLE_BIT];
    endproperty
    a_roi: assert property (p_roi) else $error("doze not cleared"); // RL21

    property p_doze_period;
        @(posedge hclk) disable iff (!rst_n)
            (clk_div[15:11] == 5'h03 && cpu_clk_en && $stable(clk_div))
            |=> !cpu_clk_en [*1] ##1 cpu_clk_en || !clk_div[`PSWDC_CD_DOZE_ENABLE_BIT];
    endproperty
    a_doze_period: assert property (p_doze_period) else $error("doze 1:2 wrong"); // RL20

endmodule

`default_nettype wire

/* File: test/pswdc_core_model.sv */
// Core-side model issuing power-save instructions and interrupt requests
`timescale 1ns/100ps
`default_nettype none

module pswdc_core_model
    import pswdc_pkg::*;
(
    // Clock
    input  wire logic        hclk,
    // Block status
    input  wire logic        core_asleep,
    // Requests to the block
    output pswdc_psave_req_t psave_req,
    output logic             irq_pending
);
    // ----------------------------------------
    // Instruction and interrupt drivers
    // ----------------------------------------
    // Quiet core at time zero
    initial begin
        psave_req   = '0;
        irq_pending = 1'b0;
    end

    // One-cycle pulse; a stopped core cannot execute anything
    task automatic psave(input logic to_sleep, input logic with_irq);
        if (core_asleep === 1'b0) begin
            psave_req   <= '{valid: 1'b1, to_sleep: to_sleep};
            irq_pending <= with_irq;
            @(posedge hclk);
            psave_req   <= '0;
            irq_pending <= 1'b0;
        end
    endtask

    // Level held by the caller until the block has answered
    task automatic set_irq(input logic level);
        irq_pending <= level;
    endtask
endmodule

`default_nettype wire

/* File: test/testbench.sv */
// Register-level bench for the power-save block with a core model
`timescale 1ns/100ps
`default_nettype none
`include "pswdc_map.svh"

module testbench;
    import pswdc_pkg::*;

    logic             hclk, hresetn, por_n, hsel, hwrite, fuse, pin;
    logic [7:0]       haddr;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic [31:0]      hwdata, hrdata;
    logic             hreadyout, hresp, cpu_clk_en, core_asleep, wake_event, wake_sink_on;
    logic             irq_pending;
    pswdc_psave_req_t psave_req;
    pswdc_regulator_t regulator;
    int               failures, n_compared;
    logic [2:0]       cf [5] = '{3'b001, 3'b000, 3'b010, 3'b111, 3'b110};

    pswdc_ctrl dut (.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .psave_req(psave_req), .irq_pending(irq_pending), .cpu_clk_en(cpu_clk_en),
        .core_asleep(core_asleep), .wake_event(wake_event), .retention_config_fuse(fuse),
        .wake_sense_pin(pin), .wake_sink_on(wake_sink_on), .regulator(regulator));

    pswdc_core_model core (.hclk(hclk), .core_asleep(core_asleep),
        .psave_req(psave_req), .irq_pending(irq_pending));

    // ----------------------------------------
    // Clock and helpers
    // ----------------------------------------
    initial hclk = 1'b0;
    always #5 hclk = ~hclk;

    task automatic end_of_test();
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bounded wait for hready at a rising edge
    task automatic edge_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            chk(32'(hreadyout), 32'h1);
            end_of_test();
        end
    endtask

    // One single word transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        edge_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        edge_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(a, 1'b0, 32'h0, x);
        chk(x, exp);
    endtask

    // Counts edges until the return-to-run pulse, noting any stopped cycle
    task automatic wait_wake(input int lim, output int cyc, output logic seen);
        cyc  = 0;
        seen = 1'b0;
        while (wake_event !== 1'b1 && cyc < lim) begin
            @(posedge hclk);
            cyc++;
            if (core_asleep === 1'b1) seen = 1'b1;
        end
        if (wake_event !== 1'b1) begin
            chk(32'(wake_event), 32'h1);
            end_of_test();
        end
    endtask

    // Regulator outputs expected in Sleep: {main state, retention on, flash powered}
    function automatic logic [3:0] exp_reg(input logic f, input logic r, input logic s);
        pswdc_reg_state_t m;
        m = s ? PSWDC_REG_FULL : ((!f && r) ? PSWDC_REG_OFF : PSWDC_REG_STANDBY);
        return {m, !f && r && !s, s};
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int   k, cnt, cyc;
        logic seen;
        hresetn = 1'b0;
        por_n = 1'b1;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        fuse = 1'b1;
        pin = 1'b1;
        failures = 0;
        n_compared = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(`PSWDC_OFS_WAKE_CTRL, 32'h0);
        rd_chk(`PSWDC_OFS_CLK_DIV, 32'h0);
        rd_chk(`PSWDC_OFS_RESET_CTRL, 32'h0);
        // Control bits, unimplemented bits and the sink output
        wr(`PSWDC_OFS_WAKE_CTRL, 32'h0000ffff);
        rd_chk(`PSWDC_OFS_WAKE_CTRL, 32'h0000a100);
        chk(32'(wake_sink_on), 32'h1);
        // Sink output is read one edge after the write has landed
        wr(`PSWDC_OFS_WAKE_CTRL, 32'h00008000);
        @(posedge hclk);
        chk(32'(wake_sink_on), 32'h0);
        wr(`PSWDC_OFS_WAKE_CTRL, 32'h00000100);
        @(posedge hclk);
        chk(32'(wake_sink_on), 32'h0);
        wr(8'h20, 32'h0000ffff);
        rd_chk(8'h20, 32'h0);
        rd_chk(`PSWDC_OFS_WAKE_CTRL, 32'h00000100);
        // Every ratio code, then ratio 7 with doze off; counts divide 256 evenly
        for (k = 0; k < 9; k++) begin
            wr(`PSWDC_OFS_CLK_DIV, (k < 8) ? ((k << 12) | 32'h800) : 32'h7000);
            repeat (4) @(posedge hclk);
            cnt = 0;
            repeat (256) begin
                @(posedge hclk);
                if (cpu_clk_en === 1'b1) cnt++;
            end
            chk(32'(cnt), (k < 8) ? (32'd256 >> k) : 32'd256);
        end
        // Interrupt with and without return-to-full-speed
        wr(`PSWDC_OFS_CLK_DIV, 32'h0000b800);
        // Let the divider leave count zero so only the interrupt can raise the enable
        @(posedge hclk);
        core.set_irq(1'b1);
        @(negedge hclk);
        chk(32'(cpu_clk_en), 32'h1);
        @(posedge hclk);
        core.set_irq(1'b0);
        rd_chk(`PSWDC_OFS_CLK_DIV, 32'h0000b000);
        wr(`PSWDC_OFS_CLK_DIV, 32'h00003800);
        core.set_irq(1'b1);
        repeat (2) @(posedge hclk);
        core.set_irq(1'b0);
        rd_chk(`PSWDC_OFS_CLK_DIV, 32'h00003800);
        wr(`PSWDC_OFS_CLK_DIV, 32'h0);
        // Idle entered with a coincident interrupt must still be reached, then left
        core.psave(1'b0, 1'b1);
        wait_wake(8, cyc, seen);
        chk(32'(seen), 32'h1);
        // Regulator choice for five of the eight fuse, retention and sleep-regulator settings
        for (k = 0; k < 5; k++) begin
            fuse <= cf[k][2];
            wr(`PSWDC_OFS_RESET_CTRL, {19'h0, cf[k][1], 3'h0, cf[k][0], 8'h00});
            repeat (3) @(posedge hclk);
            core.psave(1'b1, 1'b0);
            @(posedge hclk);
            chk(32'(regulator), 32'(exp_reg(cf[k][2], cf[k][1], cf[k][0])));
            core.set_irq(1'b1);
            wait_wake(400, cyc, seen);
            core.set_irq(1'b0);
            chk(32'(cyc >= `PSWDC_SETTLE_CYC), 32'(exp_reg(cf[k][2], cf[k][1], cf[k][0]) == 4'ha));
            @(posedge hclk);
            chk(32'({regulator.main_state, regulator.retention_on}), 32'h0);
        end
        // Charged pin, then input, then unit and sink on, then Sleep
        fuse <= 1'b1;
        wr(`PSWDC_OFS_RESET_CTRL, 32'h0);
        pin <= 1'b1;
        wr(`PSWDC_OFS_WAKE_CTRL, 32'h00008100);
        @(posedge hclk);
        chk(32'(wake_sink_on), 32'h1);
        core.psave(1'b1, 1'b0);
        repeat (2) @(posedge hclk);
        // Node only discharges while the sink draws current
        pin <= ~wake_sink_on;
        wait_wake(16, cyc, seen);
        chk(32'(seen), 32'h1);
        pin <= 1'b1;
        repeat (3) @(posedge hclk);
        rd_chk(`PSWDC_OFS_IFLAG5, 32'h1);
        wr(`PSWDC_OFS_IFLAG5, 32'h0);
        rd_chk(`PSWDC_OFS_IFLAG5, 32'h0);
        // Supply-monitor reset in mid-run
        wr(`PSWDC_OFS_WAKE_CTRL, 32'h0000a100);
        wr(`PSWDC_OFS_CLK_DIV, 32'h0000b800);
        por_n <= 1'b0;
        repeat (2) @(posedge hclk);
        por_n <= 1'b1;
        @(posedge hclk);
        rd_chk(`PSWDC_OFS_WAKE_CTRL, 32'h0);
        rd_chk(`PSWDC_OFS_CLK_DIV, 32'h0);
        end_of_test();
    end
endmodule

`default_nettype wire
